/* File: common/timer_pkg.sv */
// Purpose: Shared constants and carriers for the dual timer/counter unit.
// Assumes: One 200 MHz clock; software registers reach the block as ports.
// Notes:   Bit positions follow the control and mode register layouts.
package timer_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   // Peripheral clock periods per peripheral cycle.
   localparam int PER_CYCLE_CLKS = 6;
   localparam logic [2:0] PRESCALE_LAST = 3'(PER_CYCLE_CLKS - 1);

   // ==========================================================
   // Register field positions
   // ==========================================================
   // Control register: timer 0 uses bits 0,1,4,5; timer 1 bits 2,3,6,7.
   localparam int CTL_RUN0  = 4;
   localparam int CTL_FLAG0 = 5;
   localparam int CTL_RUN1  = 6;
   localparam int CTL_FLAG1 = 7;
   // Mode register nibble: bit 3 gate, bit 2 source, bits 1:0 mode.
   localparam int MOD_GATE  = 3;
   localparam int MOD_SRC   = 2;
   localparam int MOD_HI    = 1;
   localparam int MOD_LO    = 0;
   localparam int PRESC_W   = 5;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] CTL_RST   = 8'h00;
   localparam logic [7:0] MODE_RST  = 8'h00;

   typedef enum logic [1:0] {
      MODE_13BIT,
      MODE_16BIT,
      MODE_RELOAD,
      MODE_SPLIT
   } timer_mode_e;

   // Per-timer configuration decoded from the mode nibble.
   typedef struct packed {
      logic        gate;
      logic        src_ext;
      timer_mode_e mode;
   } timer_cfg_s;

   // Software write of one count byte.
   typedef struct packed {
      logic       wr_low;
      logic       wr_high;
      logic [7:0] data;
   } count_wr_s;

   function automatic timer_cfg_s decode_nibble(input logic [3:0] nib);
      timer_cfg_s c;
      c.gate    = nib[MOD_GATE];
      c.src_ext = nib[MOD_SRC];
      c.mode    = timer_mode_e'({nib[MOD_HI], nib[MOD_LO]});
      return c;
   endfunction

endpackage

/* File: hdl/dual_timer_counter_unit.sv */
// Purpose: Two timer/counters with four modes, gating and overflow flags.
// Assumes: Software bits arrive as ports; pins synchronous to CLOCK.
// Notes:   Count byte writes should only happen with the run bit clear.
// Notes on behaviour
// - Low byte overflow bumps high byte; high overflow sets flag.
// - Setting run starts from held count, never clears bytes.
// - Counts readable anytime; software presets only while stopped (the unit also takes count writes while running).
// - Source 0 counts peripheral cycles of six clocks; 1 counts pin.
// - Pin sampled each cycle; high then low sample increments.
// - Gate clear: run alone enables; gate set adds interrupt pin.
// - Gated timer counts only while pin high and run set.
// - Rollover from all ones sets flag, raising interrupt request.
// - Mode 0: 5-bit prescaler in low byte drives high byte.
// - Mode 1: full 16-bit cascaded counter.
// - Mode 2: low byte reloads from high byte on overflow.
// - Mode 2 reload value may change anytime, used next overflow.
// - Timer 0 mode 3 splits; high byte uses timer 1 run, flag.
// - Timer 1 in mode 3 halts and holds its count.
// - Timer 0 low mode nibble, timer 1 high nibble.
// - Mode codes: 13-bit, 16-bit, reload, split or halt.
// - Flag cleared by hardware when processor vectors to it.
// - Request passes only with timer enable and global enable.
// - Timer 1 serves as baud rate source.
`timescale 1ns/100ps
module dual_timer_counter_unit (
   // Clock and reset
   input  wire logic                  CLOCK,
   input  wire logic                  RESET_N,
   // Software control
   input  wire logic [7:0]            TIMER_MODE_REG,
   input  wire logic                  RUN0,
   input  wire logic                  RUN1,
   input  wire logic                  IRQ_EN0,
   input  wire logic                  IRQ_EN1,
   input  wire logic                  GLOBAL_IRQ_EN,
   input  wire logic                  VECTOR0,
   input  wire logic                  VECTOR1,
   input  wire timer_pkg::count_wr_s  WR0,
   input  wire timer_pkg::count_wr_s  WR1,
   // Pins
   input  wire logic                  COUNT_PIN0,
   input  wire logic                  COUNT_PIN1,
   input  wire logic                  EXT_INT_PIN0,
   input  wire logic                  EXT_INT_PIN1,
   // Status
   output logic [7:0]                 COUNT_LOW0,
   output logic [7:0]                 COUNT_HIGH0,
   output logic [7:0]                 COUNT_LOW1,
   output logic [7:0]                 COUNT_HIGH1,
   output logic                       FLAG0,
   output logic                       FLAG1,
   output logic                       IRQ0,
   output logic                       IRQ1,
   output logic                       OVF_PULSE0,
   output logic                       OVF_PULSE1
);
   import timer_pkg::*;

   // ==========================================================
   // Reset synchroniser
   // ==========================================================
   logic rst_meta_r;
   logic rst_n;

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // ==========================================================
   // Peripheral cycle and pin sampling
   // ==========================================================
   logic tick;
   logic fall0;
   logic fall1;

   timer_prescaler u_presc (
      .clk   (CLOCK),
      .rst_n (rst_n),
      .tick  (tick)
   );

   timer_edge_sampler u_edge0 (
      .clk   (CLOCK),
      .rst_n (rst_n),
      .tick  (tick),
      .pin   (COUNT_PIN0),
      .fall  (fall0)
   );

   timer_edge_sampler u_edge1 (
      .clk   (CLOCK),
      .rst_n (rst_n),
      .tick  (tick),
      .pin   (COUNT_PIN1),
      .fall  (fall1)
   );

   // ==========================================================
   // Configuration decode
   // ==========================================================
   timer_cfg_s cfg0;
   timer_cfg_s cfg1;
   logic       split;

   assign cfg0  = decode_nibble(TIMER_MODE_REG[3:0]);
   assign cfg1  = decode_nibble(TIMER_MODE_REG[7:4]);
   assign split = (cfg0.mode == MODE_SPLIT);

   // Counting event for a timer: source select, then run and gate.
   function automatic logic count_event(input timer_cfg_s c,
                                        input logic run,
                                        input logic gpin,
                                        input logic tk,
                                        input logic fl);
      logic src;
      src = c.src_ext ? fl : tk;
      return src & run & (~c.gate | gpin);
   endfunction

   logic ev0;
   logic ev1;
   logic ev0h;

   assign ev0  = count_event(cfg0, RUN0, EXT_INT_PIN0, tick, fall0);
   assign ev1  = (cfg1.mode != MODE_SPLIT) &
                 count_event(cfg1, RUN1, EXT_INT_PIN1, tick, fall1);
   // high byte of timer 0 borrows timer 1 run bit
   assign ev0h = split & tick & RUN1;

   // ==========================================================
   // Counters
   // ==========================================================
   logic [7:0] lo0_r, lo0_nxt, hi0_r, hi0_nxt;
   logic [7:0] lo1_r, lo1_nxt, hi1_r, hi1_nxt;
   logic       ovf0, ovf1, ovf0h, ovf1_t;

   // One timer's mode 0..3 stepping; returns {ovf, hi, lo}.
   function automatic logic [16:0] step(input timer_mode_e m,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
      logic [16:0] r;
      r = {1'b0, hi, lo};
      unique case (m)
         MODE_13BIT: begin
            if (lo[PRESC_W-1:0] == 5'h1F) begin
               r[PRESC_W-1:0] = 5'h00;
               {r[16], r[15:8]} = {1'b0, hi} + 9'h001;
            end else begin
               r[PRESC_W-1:0] = lo[PRESC_W-1:0] + 5'h01;
            end
         end
         MODE_16BIT: begin
            r = {1'b0, hi, lo} + 17'h00001;
         end
         MODE_RELOAD: begin
            if (lo == 8'hFF) begin
               r[7:0] = hi;
               r[16]  = 1'b1;
            end else begin
               r[7:0] = lo + 8'h01;
            end
         end
         // Split low byte: plain 8-bit counter.
         MODE_SPLIT: begin
            r[7:0] = lo + 8'h01;
            r[16]  = (lo == 8'hFF);
         end
      endcase
      return r;
   endfunction

   logic [16:0] s0, s1;

   always_comb begin
      s0      = step(cfg0.mode, lo0_r, hi0_r);
      s1      = step(cfg1.mode, lo1_r, hi1_r);
      lo0_nxt = lo0_r;
      hi0_nxt = hi0_r;
      lo1_nxt = lo1_r;
      hi1_nxt = hi1_r;
      ovf0    = 1'b0;
      ovf0h   = 1'b0;
      ovf1_t  = 1'b0;
      if (ev0) begin
         lo0_nxt = s0[7:0];
         if (!split) begin
            hi0_nxt = s0[15:8];
         end
         ovf0 = s0[16];
      end
      if (ev0h) begin
         hi0_nxt = hi0_r + 8'h01;
         ovf0h   = (hi0_r == 8'hFF);
      end
      if (ev1) begin
         lo1_nxt = s1[7:0];
         hi1_nxt = s1[15:8];
         ovf1_t  = s1[16];
      end
      if (WR0.wr_low) begin
         lo0_nxt = WR0.data;
      end
      if (WR0.wr_high) begin
         hi0_nxt = WR0.data;
      end
      if (WR1.wr_low) begin
         lo1_nxt = WR1.data;
      end
      if (WR1.wr_high) begin
         hi1_nxt = WR1.data;
      end
   end

   assign ovf1 = ovf1_t | ovf0h;

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         lo0_r <= COUNT_RST;
         hi0_r <= COUNT_RST;
         lo1_r <= COUNT_RST;
         hi1_r <= COUNT_RST;
      end else begin
         lo0_r <= lo0_nxt;
         hi0_r <= hi0_nxt;
         lo1_r <= lo1_nxt;
         hi1_r <= hi1_nxt;
      end
   end

   // ==========================================================
   // Flags, requests and baud ticks
   // ==========================================================
   logic flag0_r, flag0_nxt, flag1_r, flag1_nxt;
   logic pulse0_r, pulse0_nxt, pulse1_r, pulse1_nxt;

   always_comb begin
      flag0_nxt  = ovf0 | (flag0_r & ~VECTOR0);
      flag1_nxt  = ovf1 | (flag1_r & ~VECTOR1);
      // timer 1 pulse serves the baud generator
      pulse0_nxt = ovf0;
      pulse1_nxt = ovf1;
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         flag0_r  <= 1'b0;
         flag1_r  <= 1'b0;
         pulse0_r <= 1'b0;
         pulse1_r <= 1'b0;
      end else begin
         flag0_r  <= flag0_nxt;
         flag1_r  <= flag1_nxt;
         pulse0_r <= pulse0_nxt;
         pulse1_r <= pulse1_nxt;
      end
   end

   assign COUNT_LOW0  = lo0_r;
   assign COUNT_HIGH0 = hi0_r;
   assign COUNT_LOW1  = lo1_r;
   assign COUNT_HIGH1 = hi1_r;
   assign FLAG0       = flag0_r;
   assign FLAG1       = flag1_r;
   assign IRQ0        = flag0_r & IRQ_EN0 & GLOBAL_IRQ_EN;
   assign IRQ1        = flag1_r & IRQ_EN1 & GLOBAL_IRQ_EN;
   assign OVF_PULSE0  = pulse0_r;
   assign OVF_PULSE1  = pulse1_r;

   // ==========================================================
   // Checks
   // ==========================================================
   a_flag_on_ovf : assert property (@(posedge CLOCK) disable iff (!rst_n)
      ovf0 |=> FLAG0 && OVF_PULSE0)
      else $error("timer 0 overflow did not set flag");
   a_pulse_one_cycle : assert property (@(posedge CLOCK) disable iff (!rst_n)
      OVF_PULSE1 |=> !OVF_PULSE1)
      else $error("overflow pulse longer than one cycle");
   a_halt_holds : assert property (@(posedge CLOCK) disable iff (!rst_n)
      (cfg1.mode == MODE_SPLIT) && !WR1.wr_low && !WR1.wr_high
      |=> $stable(COUNT_LOW1) && $stable(COUNT_HIGH1))
      else $error("timer 1 moved while halted");
   a_stop_holds : assert property (@(posedge CLOCK) disable iff (!rst_n)
      !RUN0 && !WR0.wr_low && !WR0.wr_high && !split
      |=> $stable(COUNT_LOW0) && $stable(COUNT_HIGH0))
      else $error("timer 0 counted while stopped");
   a_gate_blocks : assert property (@(posedge CLOCK) disable iff (!rst_n)
      cfg0.gate && !EXT_INT_PIN0 |-> !ev0)
      else $error("gated timer 0 counted with pin low");
   a_reload_value : assert property (@(posedge CLOCK) disable iff (!rst_n)
      ev1 && cfg1.mode == MODE_RELOAD && lo1_r == 8'hFF && !WR1.wr_low
      |=> COUNT_LOW1 == $past(COUNT_HIGH1))
      else $error("reload did not take high byte");
   a_prescale_wrap : assert property (@(posedge CLOCK) disable iff (!rst_n)
      ev0 && cfg0.mode == MODE_13BIT && lo0_r[4:0] == 5'h1F && !WR0.wr_high
      |=> COUNT_HIGH0 == $past(hi0_r) + 8'h01)
      else $error("prescaler wrap did not step high byte");
   a_irq_gated : assert property (@(posedge CLOCK) disable iff (!rst_n)
      IRQ1 |-> FLAG1 && IRQ_EN1 && GLOBAL_IRQ_EN)
      else $error("request without both enables");
   a_vector_clears : assert property (@(posedge CLOCK) disable iff (!rst_n)
      VECTOR0 && !ovf0 |=> !FLAG0)
      else $error("vector did not clear flag");
endmodule

/* File: hdl/timer_edge_sampler.sv */
// Purpose: Samples a count pin once per peripheral cycle, flags falls.
// Assumes: Pin is synchronous to CLOCK; tick marks a peripheral cycle.
// Notes:   A fall is a high sample followed by a low sample.
`timescale 1ns/100ps
module timer_edge_sampler (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Sampling
   input  wire logic tick,
   input  wire logic pin,
   // Result
   output logic      fall
);
   logic prev_r;
   logic prev_nxt;
   logic fall_r;
   logic fall_nxt;

   always_comb begin
      prev_nxt = prev_r;
      fall_nxt = 1'b0;
      if (tick) begin
         prev_nxt = pin;
         fall_nxt = prev_r & ~pin;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 1'b0;
         fall_r <= 1'b0;
      end else begin
         prev_r <= prev_nxt;
         fall_r <= fall_nxt;
      end
   end

   assign fall = fall_r;

   a_fall_needs_tick : assert property (@(posedge clk) disable iff (!rst_n)
      fall |-> $past(tick) && !$past(pin))
      else $error("fall pulse without a low sample on a tick");
endmodule

/* File: hdl/timer_prescaler.sv */
// Purpose: Divides CLOCK into one-clock peripheral cycle ticks.
// Assumes: Runs freely from reset.
// Notes:   One tick every PER_CYCLE_CLKS clocks.
`timescale 1ns/100ps
module timer_prescaler (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Tick
   output logic      tick
);
   import timer_pkg::*;
   logic [2:0] cnt_r;
   logic [2:0] cnt_nxt;

   always_comb begin
      if (cnt_r == PRESCALE_LAST) begin
         cnt_nxt = 3'h0;
      end else begin
         cnt_nxt = cnt_r + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 3'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign tick = (cnt_r == PRESCALE_LAST);

   a_tick_period : assert property (@(posedge clk) disable iff (!rst_n)
      tick |=> !tick [*5] ##1 tick)
      else $error("tick period is not six clocks");
endmodule

/* File: tb/count_pin_source.sv */
// Purpose: Model of the external sources that drive the two count pins.
// Assumes: The bench calls falls() just after a falling clock edge.
// Notes:   Count pins idle high, so no stray fall appears between bursts.
`timescale 1ns/100ps
module count_pin_source #(
   parameter int HOLD_CLKS = 7
) (
   // Clock
   input  wire logic clk,
   // Count pins
   output logic      cnt_pin0,
   output logic      cnt_pin1
);
   initial begin
      cnt_pin0 = 1'b1;
      cnt_pin1 = 1'b1;
   end

   // ==========================================================
   // Falling edge bursts
   // ==========================================================
   // level held long
   // Each level outlasts one peripheral cycle, so every level is sampled.
   task automatic falls(input bit which, input int n);
      for (int i = 0; i < n; i++) begin
         if (which) cnt_pin1 = 1'b0;
         else cnt_pin0 = 1'b0;
         repeat (HOLD_CLKS) @(negedge clk);
         if (which) cnt_pin1 = 1'b1;
         else cnt_pin0 = 1'b1;
         repeat (HOLD_CLKS) @(negedge clk);
      end
   endtask
endmodule

/* File: tb/dual_timer_counter_unit_tb.sv */
// Purpose: Self-checking bench for the dual timer/counter unit.
// Assumes: Inputs change at the falling clock edge; outputs read there.
// Notes:   Rates are measured in steady state over 30 clocks.
`timescale 1ns/100ps
module dual_timer_counter_unit_tb;
   import timer_pkg::*;

   // ==========================================================
   // Signals
   // ==========================================================
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] mode_reg = 8'h00;
   logic       run0 = 1'b0, run1 = 1'b0;
   logic       interrupt_enable_register = 1'b0, ien1 = 1'b0, gen = 1'b0;
   logic       vec0 = 1'b0, vec1 = 1'b0;
   count_wr_s  wr0 = '0, wr1 = '0;
   logic       cpin0, cpin1;
   logic       ext0 = 1'b0, ext1 = 1'b0;
   logic [7:0] low0, high0, low1, high1;
   logic       flag0, flag1, irq0, irq1, ovf0, ovf1;
   logic [7:0] a;
   int         err_count = 0;
   int         n_tests = 0;
   int         cycles = 0;

   always #2.5 clk = ~clk;

   dual_timer_counter_unit u_dut (
      .CLOCK(clk), .RESET_N(rst_n), .TIMER_MODE_REG(mode_reg),
      .RUN0(run0), .RUN1(run1), .IRQ_EN0(interrupt_enable_register), .IRQ_EN1(ien1),
      .GLOBAL_IRQ_EN(gen), .VECTOR0(vec0), .VECTOR1(vec1),
      .WR0(wr0), .WR1(wr1), .COUNT_PIN0(cpin0), .COUNT_PIN1(cpin1),
      .EXT_INT_PIN0(ext0), .EXT_INT_PIN1(ext1),
      .COUNT_LOW0(low0), .COUNT_HIGH0(high0), .COUNT_LOW1(low1),
      .COUNT_HIGH1(high1), .FLAG0(flag0), .FLAG1(flag1), .IRQ0(irq0),
      .IRQ1(irq1), .OVF_PULSE0(ovf0), .OVF_PULSE1(ovf1));

   count_pin_source u_pins (.clk(clk), .cnt_pin0(cpin0), .cnt_pin1(cpin1));

   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic end_sim;
      if (err_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] exp,
                        input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask

   // One-cycle write strobe, then one idle cycle before the next write.
   task automatic wr(input bit t, input bit hi, input logic [7:0] d);
      count_wr_s w;
      w = '{wr_low: !hi, wr_high: hi, data: d};
      if (t) wr1 = w;
      else wr0 = w;
      step(1);
      wr0 = '0;
      wr1 = '0;
      step(1);
   endtask

   function automatic logic [7:0] get(input int sel);
      case (sel)
         0: return low0;
         1: return high0;
         2: return low1;
         default: return high1;
      endcase
   endfunction

   task automatic rate(input string name, input int sel, input int inc);
      step(12);
      a = get(sel);
      step(30);
      check(name, a + 8'(inc), get(sel));
   endtask

   task automatic wait_flag(input bit t);
      for (int k = 0; k < 2000; k++) begin
         if ((t ? flag1 : flag0) === 1'b1) break;
         step(1);
      end
   endtask

   // Walks all enable pairs while the flag is up, then clears it.
   task automatic irq_clear(input bit t);
      for (int i = 0; i < 4; i++) begin
         {interrupt_enable_register, gen} = 2'(i);
         ien1 = interrupt_enable_register;
         #1;
         check("irq", {7'h00, i == 3}, {7'h00, t ? irq1 : irq0});
         step(1);
      end
      {interrupt_enable_register, ien1, gen} = 3'b000;
      if (t) vec1 = 1'b1;
      else vec0 = 1'b1;
      step(1);
      vec0 = 1'b0;
      vec1 = 1'b0;
      check("flag cleared", 8'h00, {7'h00, t ? flag1 : flag0});
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         end_sim();
      end
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      step(8);
      rst_n = 1'b1;
      step(4);
      for (int s = 0; s < 4; s++) check("reset count", 8'h00, get(s));
      check("reset flags", 8'h00, {6'h00, flag1, flag0});

      // Sixteen-bit timer: preset, rate, rollover.
      mode_reg = 8'h01;
      wr(0, 0, 8'h05);
      wr(0, 1, 8'h12);
      check("preset low", 8'h05, low0);
      run0 = 1'b1;
      step(12);
      check("high after run", 8'h12, high0);
      rate("timer rate", 0, 5);
      run0 = 1'b0;
      wr(0, 0, 8'hFF);
      wr(0, 1, 8'hFF);
      run0 = 1'b1;
      wait_flag(0);
      check("rolled high", 8'h00, high0);
      check("rolled low", 8'h00, low0);
      check("pulse", 8'h01, {7'h00, ovf0});
      step(1);
      check("pulse end", 8'h00, {7'h00, ovf0});
      check("flag held", 8'h01, {7'h00, flag0});
      irq_clear(0);
      run0 = 1'b0;

      // Thirteen-bit mode: prescaler rolls into the high byte.
      mode_reg = 8'h00;
      wr(0, 1, 8'h05);
      wr(0, 0, 8'h1E);
      run0 = 1'b1;
      for (int k = 0; k < 100 && low0[4:0] !== 5'h00; k++) step(1);
      check("prescaled high", 8'h06, high0);
      run0 = 1'b0;

      // Gated counting.
      mode_reg = 8'h09;
      run0 = 1'b1;
      rate("gate low", 0, 0);
      ext0 = 1'b1;
      rate("gate high", 0, 5);
      ext0 = 1'b0;
      run0 = 1'b0;

      // Counter operation on both pins.
      mode_reg = 8'h55;
      wr(0, 0, 8'h00);
      wr(1, 0, 8'h00);
      run0 = 1'b1;
      run1 = 1'b1;
      step(12);
      u_pins.falls(0, 5);
      u_pins.falls(1, 3);
      step(20);
      check("falls t0", 8'h05, low0);
      check("falls t1", 8'h03, low1);
      run0 = 1'b0;
      run1 = 1'b0;

      // Timer 1 auto-reload, reload value changed while running.
      mode_reg = 8'h20;
      wr(1, 1, 8'hFE);
      wr(1, 0, 8'hFE);
      run1 = 1'b1;
      wait_flag(1);
      check("reload low", 8'hFE, low1);
      check("reload high", 8'hFE, high1);
      check("baud tick", 8'h01, {7'h00, ovf1});
      irq_clear(1);
      wr(1, 1, 8'hF0);
      wait_flag(1);
      check("new reload", 8'hF0, low1);
      irq_clear(1);
      run1 = 1'b0;

      // Split timer 0, timer 1 halted.
      mode_reg = 8'h33;
      wr(0, 1, 8'h00);
      wr(0, 0, 8'h00);
      wr(1, 0, 8'h11);
      run1 = 1'b1;
      rate("split high", 1, 5);
      check("split low idle", 8'h00, low0);
      check("halted t1", 8'h11, low1);
      run1 = 1'b0;
      wr(0, 1, 8'hFF);
      run1 = 1'b1;
      wait_flag(1);
      check("split flag", 8'h02, {6'h00, flag1, flag0});
      run1 = 1'b0;

      // Timer 1 gated by its own interrupt pin.
      mode_reg = 8'h90;
      run1 = 1'b1;
      rate("gate1 low", 2, 0);
      ext1 = 1'b1;
      rate("gate1 high", 2, 5);
      ext1 = 1'b0;
      run1 = 1'b0;
      end_sim();
   end
endmodule
